// ### mac_mode_defs.svh
// constants of the mac mode register bank
// assumes inclusion by the register bank and its bench
`ifndef MAC_MODE_DEFS_SVH
`define MAC_MODE_DEFS_SVH
`define MODE_ADDR        8'h00
`define CTRL_ADDR        8'h04
`define STATUS_ADDR      8'h08
`define INIT_ADDR        8'h0c
`define ADDR_W           8
`define BIT_ACCEPT_ALL_FRAMES         15
`define BIT_BCREJ        14
`define BIT_OWNOFF       13
`define SEL_HI           8
`define SEL_LO           7
`define BIT_INNER        6
`define BIT_RETRY        5
`define BIT_COLL         4
`define BIT_FCS          3
`define BIT_LOOP         2
`define BIT_TXOFF        1
`define BIT_RXOFF        0
`define MODE_MASK        32'h0000_e1ff
`define SEL_MII          2'h3
`define SEL_SERIAL       2'h2
`define CTRL_STOP        0
`define CTRL_SUSPEND     1
`define CTRL_RUN         2
`define CTRL_SOFT_RESET  3
`define CTRL_PHY_INNER   4
`define RETRY_LIMIT      5'h10
`define SINGLE_TRY       5'h01
`define PROTECT_BYTES    7'h40
`define SHORT_FRAME      11'h040
`endif

// ### mac_mode_pkg.sv
// types of the mac mode register bank
// assumes nothing beyond the constants header
package mac_mode_pkg;
   typedef struct packed {
      logic       accept_all_frames;
      logic       broadcast_reject;
      logic       own_address_match_off;
      logic [1:0] medium_selector;
      logic       inner_loop;
      logic       retry_off;
      logic       collision_inject;
      logic       fcs_append_off;
      logic       loopback;
      logic       transmit_off;
      logic       receive_off;
   } mode_fields_t;

   typedef enum logic [1:0] {
      loop_normal,
      loop_internal,
      loop_external,
      loop_illegal
   } loop_mode_t;

   typedef struct packed {
      logic       per_frame_fcs_request;
      logic       end_of_packet_flag;
      logic       auto_pad_tx;
      logic       short_frame;
   } frame_info_t;
endpackage

// ### mac_mode_register.sv
// mac mode register bank: mode word, run control, status, ahb-lite slave
// assumes one ahb-lite master, single word transfers, all on hclk
`include "mac_mode_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module mac_mode_register
   import mac_mode_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        init_load,
   input  wire logic [15:0] init_mode,
   input  wire logic        frame_is_broadcast,
   input  wire logic        frame_hits_station,
   input  wire logic        frame_hits_filter,
   input  wire frame_info_t frame_info,
   output logic             frame_accept,
   output logic             append_fcs,
   output logic             force_collision,
   output logic [4:0]       attempt_limit,
   output logic             protect_fifo_head,
   output logic             full_duplex_test,
   output loop_mode_t       loop_mode,
   output logic             mii_port_selected,
   output logic             serial_port_selected,
   output logic             transmitter_on,
   output logic             receiver_on,
   output logic             tx_ring_enable,
   output logic             rx_ring_enable
);
   mode_fields_t mode;
   logic         stop_bit;
   logic         suspend_bit;
   logic         run_request;
   logic         phy_port_inner_loop;
   logic         soft_reset;

   logic         dphase;
   logic         dwrite;
   logic [`ADDR_W-1:0] daddr;
   logic         accessible;
   logic [31:0]  mode_word;
   logic [31:0]  next_rdata;
   mode_fields_t next_mode;
   logic         mode_wr;
   loop_mode_t   next_loop;

   // register open only when stopped or suspended
   assign accessible = stop_bit | suspend_bit;

   // soft reset acts on the edge that ends the control write; a read issued
   // right after that write samples on that same edge and still sees the old mode word
   assign soft_reset = dphase & dwrite & (daddr == `CTRL_ADDR) & hwdata[`CTRL_SOFT_RESET];

   always_comb begin
      mode_word = 32'h0000_0000;
      mode_word[`BIT_ACCEPT_ALL_FRAMES]          = mode.accept_all_frames;
      mode_word[`BIT_BCREJ]         = mode.broadcast_reject;
      mode_word[`BIT_OWNOFF]        = mode.own_address_match_off;
      mode_word[`SEL_HI:`SEL_LO]    = mode.medium_selector;
      mode_word[`BIT_INNER]         = mode.inner_loop;
      mode_word[`BIT_RETRY]         = mode.retry_off;
      mode_word[`BIT_COLL]          = mode.collision_inject;
      mode_word[`BIT_FCS]           = mode.fcs_append_off;
      mode_word[`BIT_LOOP]          = mode.loopback;
      mode_word[`BIT_TXOFF]         = mode.transmit_off;
      mode_word[`BIT_RXOFF]         = mode.receive_off;
   end

   // address phase capture; slave never inserts waits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dphase <= 1'b0;
         dwrite <= 1'b0;
         daddr  <= '0;
      end else if (hready) begin
         dphase <= hsel & htrans[1];
         dwrite <= hwrite;
         daddr  <= haddr[`ADDR_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // source of the mode word: init block or host data phase
   // reserved bits dropped by the mask
   always_comb begin
      logic [31:0] src;
      src     = `MODE_MASK & (init_load ? {16'h0000, init_mode} : hwdata);
      mode_wr = init_load | (dphase & dwrite & (daddr == `MODE_ADDR) & accessible);
      next_mode.accept_all_frames     = src[`BIT_ACCEPT_ALL_FRAMES];
      next_mode.broadcast_reject      = src[`BIT_BCREJ];
      next_mode.own_address_match_off = src[`BIT_OWNOFF];
      next_mode.medium_selector       = src[`SEL_HI:`SEL_LO];
      next_mode.inner_loop            = src[`BIT_INNER];
      next_mode.retry_off             = src[`BIT_RETRY];
      next_mode.collision_inject      = src[`BIT_COLL];
      next_mode.fcs_append_off        = src[`BIT_FCS];
      next_mode.loopback              = src[`BIT_LOOP];
      next_mode.transmit_off          = src[`BIT_TXOFF];
      next_mode.receive_off           = src[`BIT_RXOFF];
   end

   // host write while running leaves the word untouched
   // soft reset clears; stop is not a reset here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode <= '0;
      end else if (soft_reset) begin
         mode <= '0;
      end else if (mode_wr) begin
         mode <= next_mode;
      end
   end

   // run control: stop, suspend, run request, phy inner loop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_bit            <= 1'b1;
         suspend_bit         <= 1'b0;
         run_request         <= 1'b0;
         phy_port_inner_loop <= 1'b0;
      end else begin
         if (dphase && dwrite && daddr == `CTRL_ADDR) begin
            suspend_bit         <= hwdata[`CTRL_SUSPEND];
            phy_port_inner_loop <= hwdata[`CTRL_PHY_INNER];
            // run wins over stop when both are written
            run_request <= hwdata[`CTRL_RUN];
            stop_bit    <= hwdata[`CTRL_STOP] & ~hwdata[`CTRL_RUN];
         end
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (haddr[`ADDR_W-1:0])
         `MODE_ADDR:   next_rdata = accessible ? mode_word : 32'h0000_0000;
         `CTRL_ADDR:   next_rdata = {27'h0, phy_port_inner_loop, 1'b0, run_request,
                                     suspend_bit, stop_bit};
         `STATUS_ADDR: next_rdata = {26'h0, loop_mode, mii_port_selected,
                                     serial_port_selected, receiver_on, transmitter_on};
         default:      next_rdata = 32'h0000_0000;
      endcase
   end

   // read data registered during the address phase window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         // loaded at the read's address phase, stands through its data phase
         hrdata <= next_rdata;
      end
   end

   always_comb begin
      next_loop = loop_illegal;
      if (mode.medium_selector == `SEL_MII) begin
         case ({mode.loopback, mode.inner_loop, phy_port_inner_loop})
            3'h0:    next_loop = loop_normal;
            3'h1:    next_loop = loop_internal;
            3'h4:    next_loop = loop_external;
            default: next_loop = loop_illegal;
         endcase
      end else begin
         case ({mode.loopback, mode.inner_loop, phy_port_inner_loop})
            3'h0:    next_loop = loop_normal;
            3'h6:    next_loop = loop_internal;
            3'h4:    next_loop = loop_external;
            default: next_loop = loop_illegal;
         endcase
      end
   end

   // datapath controls, all registered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_accept         <= 1'b0;
         append_fcs           <= 1'b1;
         force_collision      <= 1'b0;
         attempt_limit        <= `RETRY_LIMIT;
         protect_fifo_head    <= 1'b1;
         full_duplex_test     <= 1'b0;
         loop_mode            <= loop_normal;
         mii_port_selected    <= 1'b0;
         serial_port_selected <= 1'b0;
         transmitter_on       <= 1'b0;
         receiver_on          <= 1'b0;
         tx_ring_enable       <= 1'b0;
         rx_ring_enable       <= 1'b0;
      end else begin
         frame_accept <= ~mode.receive_off &
                         (mode.accept_all_frames |
                          (frame_is_broadcast & ~mode.broadcast_reject) |
                          (frame_hits_station & ~mode.own_address_match_off) |
                          frame_hits_filter);
         append_fcs <= ~mode.fcs_append_off |
                       (frame_info.per_frame_fcs_request & frame_info.end_of_packet_flag) |
                       (frame_info.auto_pad_tx & frame_info.short_frame);
         force_collision <= mode.collision_inject & (next_loop == loop_internal);
         // attempt count and fifo head guard
         attempt_limit     <= mode.retry_off ? `SINGLE_TRY : `RETRY_LIMIT;
         protect_fifo_head <= ~mode.retry_off;
         full_duplex_test     <= mode.loopback;
         loop_mode            <= next_loop;
         mii_port_selected    <= mode.medium_selector == `SEL_MII;
         serial_port_selected <= mode.medium_selector == `SEL_SERIAL;
         transmitter_on <= run_request & ~mode.transmit_off;
         tx_ring_enable <= run_request & ~mode.transmit_off;
         receiver_on    <= run_request & ~mode.receive_off;
         rx_ring_enable <= run_request & ~mode.receive_off;
      end
   end
endmodule
`default_nettype wire

// ### mac_mode_monitor.sv
// checker for the mac mode register bank outputs
// assumes a bind onto mac_mode_register, one clock hclk
`timescale 1ns/1ps
`default_nettype none
module mac_mode_monitor
   import mac_mode_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire frame_info_t frame_info,
   input wire logic        append_fcs,
   input wire logic        force_collision,
   input wire logic [4:0]  attempt_limit,
   input wire logic        protect_fifo_head,
   input wire logic        full_duplex_test,
   input wire loop_mode_t  loop_mode,
   input wire logic        mii_port_selected,
   input wire logic        serial_port_selected,
   input wire logic        transmitter_on,
   input wire logic        receiver_on,
   input wire logic        tx_ring_enable,
   input wire logic        rx_ring_enable
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_BUS: assert property (
      hreadyout && !hresp) else $error("bus answer not ready okay");
   AST_RETRY: assert property (
      attempt_limit == (protect_fifo_head ? 5'h10 : 5'h01)) else $error("retry count wrong");
   AST_COLL: assert property (
      force_collision |-> loop_mode == loop_internal) else $error("collision outside loop");
   AST_PORT: assert property (
      !(mii_port_selected && serial_port_selected)) else $error("two ports selected");
   AST_TX: assert property (
      transmitter_on == tx_ring_enable) else $error("tx ring and tx on differ");
   AST_RX: assert property (
      receiver_on == rx_ring_enable) else $error("rx ring and rx on differ");
   AST_FCS_REQ: assert property (
      frame_info.per_frame_fcs_request && frame_info.end_of_packet_flag |=> append_fcs)
      else $error("per frame fcs ignored");
   AST_PAD: assert property (
      frame_info.auto_pad_tx && frame_info.short_frame |=> append_fcs)
      else $error("short padded frame lost fcs");
   AST_DUPLEX: assert property (
      full_duplex_test |-> loop_mode != loop_normal) else $error("loopback decoded normal");
endmodule
`default_nettype wire

// ### mac_mode_register_tb.sv
// self-checking bench for the mac mode register bank
// assumes the bank is the one ahb-lite slave, hready fed from hreadyout
`include "mac_mode_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module mac_mode_register_tb import mac_mode_pkg::*;;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic        init_load = 1'b0;
   logic [15:0] init_mode = 16'h0;
   logic [2:0]  hits = 3'h0;
   frame_info_t frame_info = 4'h0;
   logic [31:0] hrdata, rd;
   logic        hreadyout, hresp, frame_accept, append_fcs, force_collision;
   logic [4:0]  attempt_limit;
   logic        protect_fifo_head, full_duplex_test, mii_port_selected;
   logic        serial_port_selected, transmitter_on, receiver_on;
   logic        tx_ring_enable, rx_ring_enable;
   loop_mode_t  loop_mode;
   int          err_total = 0;
   int          n_checks = 0;
   int          cyc = 0;
   mac_mode_register mac_mode_register_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .init_load(init_load), .init_mode(init_mode), .frame_is_broadcast(hits[2]),
      .frame_hits_station(hits[1]), .frame_hits_filter(hits[0]), .frame_info(frame_info),
      .frame_accept(frame_accept), .append_fcs(append_fcs), .force_collision(force_collision),
      .attempt_limit(attempt_limit), .protect_fifo_head(protect_fifo_head),
      .full_duplex_test(full_duplex_test), .loop_mode(loop_mode),
      .mii_port_selected(mii_port_selected), .serial_port_selected(serial_port_selected),
      .transmitter_on(transmitter_on), .receiver_on(receiver_on),
      .tx_ring_enable(tx_ring_enable), .rx_ring_enable(rx_ring_enable));
   always #12.5 hclk = ~hclk;
   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard, whole run is under 150 cycles
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         print_verdict;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task settle;
      repeat (2) @(posedge hclk);
   endtask
   task rst;
      hresetn <= 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, `MODE_ADDR, 32'h0);
      chk(rd, 32'h0);
      chk({attempt_limit, append_fcs, full_duplex_test, mii_port_selected}, 32'h84);
   endtask
   task t_reserved;
      ahb(1'b1, `MODE_ADDR, 32'hffff_ffff);
      ahb(1'b0, `MODE_ADDR, 32'h0);
      chk(rd, 32'h0000_e1ff);
      settle;
      chk({attempt_limit, protect_fifo_head, mii_port_selected}, 32'h05);
      chk(full_duplex_test, 1'b1);
   endtask
   task run_frame(input logic [15:0] m, input logic [2:0] h, input logic [3:0] fi,
                  input logic acc, input logic fcs);
      ahb(1'b1, `MODE_ADDR, {16'h0, m});
      hits <= h;
      frame_info <= fi;
      settle;
      chk({frame_accept, append_fcs}, {acc, fcs});
   endtask
   task run_loop(input logic [15:0] m, input logic [7:0] c, input loop_mode_t lm,
                 input logic coll);
      ahb(1'b1, `CTRL_ADDR, {24'h0, c});
      ahb(1'b1, `MODE_ADDR, {16'h0, m});
      settle;
      chk({loop_mode, force_collision}, {lm, coll});
      ahb(1'b0, `STATUS_ADDR, 32'h0);
      chk(rd[5:4], lm);
   endtask
   task t_gate;
      ahb(1'b1, `MODE_ADDR, 32'h2);
      ahb(1'b1, `CTRL_ADDR, 32'h4);
      // the write below must be dropped while running
      ahb(1'b1, `MODE_ADDR, 32'h0);
      ahb(1'b0, `STATUS_ADDR, 32'h0);
      chk(rd[1:0], 2'h2);
      chk({transmitter_on, receiver_on}, 2'h1);
      ahb(1'b1, `CTRL_ADDR, 32'h1);
      ahb(1'b0, `MODE_ADDR, 32'h0);
      chk(rd, 32'h2);
   endtask
   task t_init;
      @(posedge hclk);
      init_mode <= 16'hffff;
      init_load <= 1'b1;
      @(posedge hclk);
      init_load <= 1'b0;
      ahb(1'b0, `MODE_ADDR, 32'h0);
      chk(rd, 32'h0000_e1ff);
      ahb(1'b1, `CTRL_ADDR, 32'h9);
      ahb(1'b0, `MODE_ADDR, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b0, `INIT_ADDR, 32'h0);
      chk(rd, 32'h0);
   endtask
   initial begin
      rst;
      t_reserved;
      run_frame(16'h8000, 3'h0, 4'h0, 1'b1, 1'b1);
      run_frame(16'h4000, 3'h4, 4'h0, 1'b0, 1'b1);
      run_frame(16'h0000, 3'h4, 4'h0, 1'b1, 1'b1);
      run_frame(16'h2000, 3'h2, 4'h0, 1'b0, 1'b1);
      run_frame(16'h0000, 3'h3, 4'h0, 1'b1, 1'b1);
      run_frame(16'h8001, 3'h7, 4'h0, 1'b0, 1'b1);
      run_frame(16'h0008, 3'h0, 4'h0, 1'b0, 1'b0);
      run_frame(16'h0008, 3'h0, 4'hc, 1'b0, 1'b1);
      run_frame(16'h0008, 3'h0, 4'h8, 1'b0, 1'b0);
      run_frame(16'h0008, 3'h0, 4'h3, 1'b0, 1'b1);
      run_frame(16'h0008, 3'h0, 4'h1, 1'b0, 1'b0);
      run_loop(16'h0000, 8'h01, loop_normal, 1'b0);
      run_loop(16'h0154, 8'h01, loop_internal, 1'b1);
      run_loop(16'h0114, 8'h01, loop_external, 1'b0);
      run_loop(16'h0190, 8'h11, loop_internal, 1'b1);
      run_loop(16'h0184, 8'h01, loop_external, 1'b0);
      t_gate;
      t_init;
      ahb(1'b1, `MODE_ADDR, 32'h4184);
      rst;
      print_verdict;
   end
endmodule
bind mac_mode_register mac_mode_monitor mac_mode_monitor_inst (.hclk(hclk),
   .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .frame_info(frame_info),
   .append_fcs(append_fcs), .force_collision(force_collision),
   .attempt_limit(attempt_limit), .protect_fifo_head(protect_fifo_head),
   .full_duplex_test(full_duplex_test), .loop_mode(loop_mode),
   .mii_port_selected(mii_port_selected), .serial_port_selected(serial_port_selected),
   .transmitter_on(transmitter_on), .receiver_on(receiver_on),
   .tx_ring_enable(tx_ring_enable), .rx_ring_enable(rx_ring_enable));
`default_nettype wire
